// >>> adcs_ctrl.sv
// Sample sequencer control of a multi-channel converter, APB slave.
// Assumes the converter core answers conv_start with conv_done on clock.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "adcs_defs.svh"
module adcs_ctrl
    import adcs_pkg::*;
#(
    parameter int DW = 12
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // External trigger pin
    input  wire logic          ext_trig,
    // Converter core
    output logic               conv_start,
    output logic [4:0]         conv_ch,
    input  wire logic          conv_done,
    input  wire logic [DW-1:0] conv_data,
    // Settings and results
    output logic [1:0]         ref_sel,
    output logic [1:0]         res_sel,
    output logic [3:0]         phase_sel,
    output logic [1:0]         cmp_band,
    output logic               irq
);
    function automatic logic [3:0] depth(input logic [1:0] s);
        if (s == 2'h0) begin
            return `ADCS_DEPTH0;
        end else if (s == 2'h3) begin
            return `ADCS_DEPTH3;
        end else begin
            return `ADCS_DEPTH1;
        end
    endfunction : depth

    function automatic logic [4:0] base(input logic [1:0] s);
        if (s == 2'h0) begin
            return 5'h00;
        end else if (s == 2'h1) begin
            return `ADCS_BASE1;
        end else if (s == 2'h2) begin
            return `ADCS_BASE2;
        end else begin
            return `ADCS_BASE3;
        end
    endfunction : base

    function automatic logic [1:0] owner(input logic [4:0] i);
        if (i < `ADCS_BASE1) begin
            return 2'h0;
        end else if (i < `ADCS_BASE2) begin
            return 2'h1;
        end else if (i < `ADCS_BASE3) begin
            return 2'h2;
        end else begin
            return 2'h3;
        end
    endfunction : owner

    adcs_state_t       state_reg, state_next;
    logic [3:0]        en_reg, en_next, ris_reg, ris_next, im_reg, im_next;
    logic [3:0]        ovf_reg, ovf_next, ufl_reg, ufl_next;
    logic [3:0]        pend_reg, pend_next;
    logic [7:0]        tsrc_reg, tsrc_next, prio_reg, prio_next;
    logic [7:0]        misc_reg, misc_next;
    logic [2:0]        os_reg, os_next;
    logic [DW-1:0]     lo_reg, lo_next, hi_reg, hi_next;
    logic [1:0]        band_reg, band_next;
    logic [6:0]        step_reg [`ADCS_NSTEP];
    logic [6:0]        step_next [`ADCS_NSTEP];
    logic [DW-1:0]     fifo_mem [4][8];
    logic [2:0]        wp_reg [4];
    logic [2:0]        wp_next [4];
    logic [2:0]        rp_reg [4];
    logic [2:0]        rp_next [4];
    logic [3:0]        cnt_reg [4];
    logic [3:0]        cnt_next [4];
    logic [1:0]        act_reg, act_next;
    logic [2:0]        stp_reg, stp_next;
    logic [6:0]        osc_reg, osc_next;
    logic [DW+5:0]     acc_reg, acc_next;
    logic              start_reg, start_next;
    logic [4:0]        ch_reg, ch_next;
    logic              rdy_reg, rdy_next, err_reg, err_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic              s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    logic              push;
    logic [DW-1:0]     push_data;
    logic [DW+5:0]     sum;
    logic [6:0]        step_word;
    logic [4:0]        sidx;
    logic [1:0]        best, ps;
    logic              found, wr, rd_lat, ext_rise, step_hit;

    assign pready     = rdy_reg;
    assign prdata     = rdata_reg;
    assign pslverr    = err_reg;
    assign conv_start = start_reg;
    assign conv_ch    = ch_reg;
    assign cmp_band   = band_reg;
    assign ref_sel    = misc_reg[1:0];
    assign res_sel    = misc_reg[3:2];
    assign phase_sel  = misc_reg[7:4];
    assign irq        = |(ris_reg & im_reg);

    always_comb begin
        // One wait state: request latched, answered next cycle
        rdy_next   = psel & penable & ~rdy_reg;
        rd_lat     = rdy_next & ~pwrite;
        wr         = psel & penable & rdy_reg & pwrite;
        lvl_next   = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
        ext_rise   = lvl_next & ~lvl_reg;
        sidx       = 5'((paddr - `ADCS_OFF_STEP) >> 2);
        // Bounded window, so high offsets never alias onto steps
        step_hit   = paddr >= `ADCS_OFF_STEP
                     && paddr < `ADCS_OFF_STEP + 12'(4 * `ADCS_NSTEP);
        en_next    = en_reg;
        im_next    = im_reg;
        tsrc_next  = tsrc_reg;
        prio_next  = prio_reg;
        os_next    = os_reg;
        misc_next  = misc_reg;
        lo_next    = lo_reg;
        hi_next    = hi_reg;
        band_next  = band_reg;
        step_next  = step_reg;
        wp_next    = wp_reg;
        rp_next    = rp_reg;
        cnt_next   = cnt_reg;
        rdata_next = rdata_reg;
        err_next   = 1'b0;
        state_next = state_reg;
        act_next   = act_reg;
        stp_next   = stp_reg;
        osc_next   = osc_reg;
        acc_next   = acc_reg;
        start_next = 1'b0;
        ch_next    = ch_reg;
        push       = 1'b0;
        sum        = acc_reg + (DW+6)'(conv_data);
        push_data  = DW'(sum >> os_reg);
        step_word  = step_reg[5'(base(act_reg) + 5'(stp_reg))];
        ris_next   = ris_reg;
        ovf_next   = ovf_reg;
        ufl_next   = ufl_reg;
        pend_next  = pend_reg;
        // Register writes
        if (wr) begin
            if (paddr == `ADCS_OFF_EN) begin
                en_next = pwdata[3:0];
            end else if (paddr == `ADCS_OFF_RIS
                         || paddr == `ADCS_OFF_ISC) begin
                ris_next = ris_reg & ~pwdata[3:0];
            end else if (paddr == `ADCS_OFF_IM) begin
                im_next = pwdata[3:0];
            end else if (paddr == `ADCS_OFF_OVF) begin
                ovf_next = ovf_reg & ~pwdata[3:0];
            end else if (paddr == `ADCS_OFF_UFL) begin
                ufl_next = ufl_reg & ~pwdata[3:0];
            end else if (paddr == `ADCS_OFF_TSRC) begin
                tsrc_next = pwdata[7:0];
            end else if (paddr == `ADCS_OFF_PRIO) begin
                prio_next = pwdata[7:0];
            end else if (paddr == `ADCS_OFF_OSMP) begin
                // one shared factor; out of range ignored
                if (pwdata[2:0] <= `ADCS_OS_MAX) begin
                    os_next = pwdata[2:0];
                end
            end else if (paddr == `ADCS_OFF_MISC) begin
                misc_next = pwdata[7:0];
            end else if (paddr == `ADCS_OFF_CMP) begin
                lo_next = pwdata[DW-1:0];
                hi_next = pwdata[DW+15:16];
            end else if (step_hit) begin
                if (!en_reg[owner(sidx)]) begin
                    step_next[sidx] = pwdata[6:0];
                end
            end
        end
        // Triggers, from the registered source, so a new source counts from the next cycle
        for (int i = 0; i < 4; i++) begin
            ps = tsrc_reg[2*i +: 2];
            if ((ps == `ADCS_TRG_ALWAYS)
                || (ps == `ADCS_TRG_EXT && ext_rise)
                || (ps == `ADCS_TRG_PROC && wr
                    && paddr == `ADCS_OFF_PTRIG && pwdata[i])) begin
                pend_next[i] = 1'b1;
            end
            if (!en_reg[i]) begin
                pend_next[i] = 1'b0;
            end
        end
        // strict priority, lower value wins, ties to lower index
        found = 1'b0;
        best  = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (pend_reg[i] && en_reg[i] && (!found
                || prio_reg[2*i +: 2] < prio_reg[2*best +: 2])) begin
                found = 1'b1;
                best  = 2'(i);
            end
        end
        case (state_reg)
            ADCS_IDLE: begin
                if (found) begin
                    act_next        = best;
                    stp_next        = 3'h0;
                    osc_next        = 7'h0;
                    acc_next        = '0;
                    pend_next[best] = 1'b0;
                    state_next      = ADCS_REQ;
                end
            end
            ADCS_REQ: begin
                // five bits, 24 is the temperature sensor
                ch_next    = step_word[4:0];
                start_next = 1'b1;
                state_next = ADCS_WAIT;
            end
            default: begin
                if (conv_done) begin
                    acc_next = sum;
                    osc_next = osc_reg + 7'h1;
                    // repeat same input until 1 << factor samples are summed
                    if ((osc_reg + 7'h1) != (7'h1 << os_reg)) begin
                        state_next = ADCS_REQ;
                    end else begin
                        push     = 1'b1;
                        acc_next = '0;
                        osc_next = 7'h0;
                        if (step_word[`ADCS_STEP_IE]) begin
                            ris_next[act_reg] = 1'b1;
                        end
                        if (push_data <= lo_reg) begin
                            band_next = `ADCS_BAND_LOW;
                        end else if (push_data <= hi_reg) begin
                            band_next = `ADCS_BAND_MID;
                        end else begin
                            band_next = `ADCS_BAND_HIGH;
                        end
                        if (step_word[`ADCS_STEP_END]
                            || 4'(stp_reg) == depth(act_reg) - 4'h1) begin
                            state_next = ADCS_IDLE;
                        end else begin
                            stp_next   = stp_reg + 3'h1;
                            state_next = ADCS_REQ;
                        end
                    end
                end
            end
        endcase
        // FIFOs; full drops the result, empty read returns zero
        for (int i = 0; i < 4; i++) begin
            if (push && act_reg == 2'(i)) begin
                if (cnt_reg[i] == depth(2'(i))) begin
                    ovf_next[i] = 1'b1;
                end else begin
                    cnt_next[i] = cnt_next[i] + 4'h1;
                    wp_next[i]  = (4'(wp_reg[i]) == depth(2'(i)) - 4'h1)
                                  ? 3'h0 : wp_reg[i] + 3'h1;
                end
            end
            if (rd_lat && paddr == `ADCS_OFF_FIFO + 12'(4*i)) begin
                if (cnt_reg[i] == 4'h0) begin
                    ufl_next[i] = 1'b1;
                end else begin
                    cnt_next[i] = cnt_next[i] - 4'h1;
                    rp_next[i]  = (4'(rp_reg[i]) == depth(2'(i)) - 4'h1)
                                  ? 3'h0 : rp_reg[i] + 3'h1;
                end
            end
        end
        // Read data and error, latched in the first access cycle
        if (rdy_next) begin
            rdata_next = 32'h0;
            if (paddr == `ADCS_OFF_EN) begin
                rdata_next[3:0] = en_reg;
            end else if (paddr == `ADCS_OFF_RIS) begin
                rdata_next[3:0] = ris_reg;
            end else if (paddr == `ADCS_OFF_IM) begin
                rdata_next[3:0] = im_reg;
            end else if (paddr == `ADCS_OFF_ISC) begin
                rdata_next[3:0] = ris_reg & im_reg;
            end else if (paddr == `ADCS_OFF_OVF) begin
                rdata_next[3:0] = ovf_reg;
            end else if (paddr == `ADCS_OFF_UFL) begin
                rdata_next[3:0] = ufl_reg;
            end else if (paddr == `ADCS_OFF_TSRC) begin
                rdata_next[7:0] = tsrc_reg;
            end else if (paddr == `ADCS_OFF_PRIO) begin
                rdata_next[7:0] = prio_reg;
            end else if (paddr == `ADCS_OFF_PTRIG) begin
                rdata_next = 32'h0;
            end else if (paddr == `ADCS_OFF_OSMP) begin
                rdata_next[2:0] = os_reg;
            end else if (paddr == `ADCS_OFF_MISC) begin
                rdata_next[7:0] = misc_reg;
            end else if (paddr == `ADCS_OFF_CMP) begin
                rdata_next[DW-1:0]   = lo_reg;
                rdata_next[DW+15:16] = hi_reg;
            end else if (paddr == `ADCS_OFF_BAND) begin
                rdata_next[1:0] = band_reg;
            end else if (paddr[11:4] == 8'(`ADCS_OFF_FIFO >> 4)
                         && paddr[1:0] == 2'h0) begin
                if (cnt_reg[paddr[3:2]] != 4'h0) begin
                    rdata_next[DW-1:0] =
                        fifo_mem[paddr[3:2]][rp_reg[paddr[3:2]]];
                end
            end else if (step_hit && paddr[1:0] == 2'h0) begin
                rdata_next[6:0] = step_reg[sidx];
            end else begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (push && cnt_reg[act_reg] != depth(act_reg)) begin
            fifo_mem[act_reg][wp_reg[act_reg]] <= push_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ADCS_IDLE;
            en_reg    <= 4'h0;
            ris_reg   <= 4'h0;
            im_reg    <= 4'h0;
            ovf_reg   <= 4'h0;
            ufl_reg   <= 4'h0;
            pend_reg  <= 4'h0;
            tsrc_reg  <= 8'h0;
            prio_reg  <= `ADCS_PRIO_RST;
            misc_reg  <= 8'h0;
            os_reg    <= 3'h0;
            lo_reg    <= '0;
            hi_reg    <= '0;
            band_reg  <= `ADCS_BAND_LOW;
            step_reg  <= '{default: 7'h0};
            wp_reg    <= '{default: 3'h0};
            rp_reg    <= '{default: 3'h0};
            cnt_reg   <= '{default: 4'h0};
            act_reg   <= 2'h0;
            stp_reg   <= 3'h0;
            osc_reg   <= 7'h0;
            acc_reg   <= '0;
            start_reg <= 1'b0;
            ch_reg    <= 5'h0;
            rdy_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h0;
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            lvl_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            en_reg    <= en_next;
            ris_reg   <= ris_next;
            im_reg    <= im_next;
            ovf_reg   <= ovf_next;
            ufl_reg   <= ufl_next;
            pend_reg  <= pend_next;
            tsrc_reg  <= tsrc_next;
            prio_reg  <= prio_next;
            misc_reg  <= misc_next;
            os_reg    <= os_next;
            lo_reg    <= lo_next;
            hi_reg    <= hi_next;
            band_reg  <= band_next;
            step_reg  <= step_next;
            wp_reg    <= wp_next;
            rp_reg    <= rp_next;
            cnt_reg   <= cnt_next;
            act_reg   <= act_next;
            stp_reg   <= stp_next;
            osc_reg   <= osc_next;
            acc_reg   <= acc_next;
            start_reg <= start_next;
            ch_reg    <= ch_next;
            rdy_reg   <= rdy_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
            s1_reg    <= ext_trig;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            lvl_reg   <= lvl_next;
        end
    end
endmodule : adcs_ctrl

// >>> adcs_defs.svh
// Register map, field positions and encodings of the sequencer control.
// Included by the control module, its monitor and the bench; definitions only.
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// Byte offsets on the register bus
`define ADCS_OFF_EN     12'h000
`define ADCS_OFF_RIS    12'h004
`define ADCS_OFF_IM     12'h008
`define ADCS_OFF_ISC    12'h00c
`define ADCS_OFF_OVF    12'h010
`define ADCS_OFF_UFL    12'h014
`define ADCS_OFF_TSRC   12'h018
`define ADCS_OFF_PRIO   12'h01c
`define ADCS_OFF_PTRIG  12'h020
`define ADCS_OFF_OSMP   12'h024
`define ADCS_OFF_MISC   12'h028
`define ADCS_OFF_CMP    12'h02c
`define ADCS_OFF_BAND   12'h030
`define ADCS_OFF_FIFO   12'h040
`define ADCS_OFF_STEP   12'h080
// Step word fields
`define ADCS_STEP_IE    5
`define ADCS_STEP_END   6
`define ADCS_CH_TEMP    5'h18
// Sequencer depths and step bases
`define ADCS_NSTEP      17
`define ADCS_DEPTH0     4'h8
`define ADCS_DEPTH1     4'h4
`define ADCS_DEPTH3     4'h1
`define ADCS_BASE1      5'h08
`define ADCS_BASE2      5'h0c
`define ADCS_BASE3      5'h10
// Trigger sources
`define ADCS_TRG_PROC   2'h0
`define ADCS_TRG_EXT    2'h1
`define ADCS_TRG_ALWAYS 2'h2
// Oversampling, comparator bands
`define ADCS_OS_MAX     3'h6
`define ADCS_BAND_LOW   2'h0
`define ADCS_BAND_MID   2'h1
`define ADCS_BAND_HIGH  2'h2
// Priority after reset: sequencer index is its rank
`define ADCS_PRIO_RST   8'he4
`endif

// >>> adcs_pkg.sv
// Types shared by the sequencer control.
// Assumes adcs_defs.svh is on the include path.
package adcs_pkg;
    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_REQ,
        ADCS_WAIT
    } adcs_state_t;
endpackage : adcs_pkg

// >>> adcs_ctrl_monitor.sv
// Port checks for the sequencer control, bound to every adcs_ctrl.
// Assumes one clock domain and the bus offsets of adcs_defs.svh.
`timescale 1ns/1ps
`include "adcs_defs.svh"
module adcs_ctrl_monitor #(
    parameter int DW = 12
) (
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst,
    // Bus
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    // Trigger and converter
    input wire logic          ext_trig,
    input wire logic          conv_start,
    input wire logic [4:0]    conv_ch,
    input wire logic          conv_done,
    input wire logic [DW-1:0] conv_data,
    // Settings and results
    input wire logic [1:0]    ref_sel,
    input wire logic [1:0]    res_sel,
    input wire logic [3:0]    phase_sel,
    input wire logic [1:0]    cmp_band,
    input wire logic          irq
);
    logic done_wr;
    logic misc_wr;
    logic mask_off;

    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (rst);

    assign done_wr  = psel && penable && pready && pwrite;
    assign misc_wr  = done_wr && paddr == `ADCS_OFF_MISC;
    assign mask_off = done_wr && paddr == `ADCS_OFF_IM && pwdata[3:0] == 4'h0;

    access_time_a:
    assert property (psel && $rose(penable) |=> pready)
        else $error("bus answer not one cycle after access start");
    ready_pulse_a:
    assert property (pready |-> psel && penable ##1 !pready)
        else $error("bus answer outside access or too long");
    error_flag_a:
    assert property (pslverr |-> pready)
        else $error("error flag without answer");
    start_pulse_a:
    assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    channel_range_a:
    assert property (conv_start |-> conv_ch <= `ADCS_CH_TEMP)
        else $error("channel beyond temperature select");
    channel_hold_a:
    assert property ($changed(conv_ch) |-> conv_start)
        else $error("channel changed without a start");
    mask_off_a:
    assert property (mask_off |=> !irq)
        else $error("interrupt high with all masks clear");
    misc_value_a:
    assert property (misc_wr |=>
        {phase_sel, res_sel, ref_sel} == $past(pwdata[7:0]))
        else $error("settings differ from written word");
    misc_hold_a:
    assert property (!$past(misc_wr) |->
        $stable({phase_sel, res_sel, ref_sel}))
        else $error("settings changed without a write");
    band_legal_a:
    assert property (cmp_band != 2'h3)
        else $error("band code outside low, mid, high");
endmodule : adcs_ctrl_monitor

bind adcs_ctrl adcs_ctrl_monitor #(.DW(DW)) mon (.clock, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .ext_trig, .conv_start, .conv_ch, .conv_done, .conv_data, .ref_sel,
    .res_sel, .phase_sel, .cmp_band, .irq);

// >>> adc_sample_sequencer_control_test.sv
// Self-checking bench: APB master and converter responder for adcs_ctrl.
// Assumes the design and its monitor are compiled before this file.
`timescale 1ns/1ps
`include "adcs_defs.svh"
module adc_sample_sequencer_control_test import adcs_pkg::*;;
    logic        clock, rst, psel, penable, pwrite, ext_trig, conv_done, jit;
    logic        pready, pslverr, conv_start, irq, e;
    logic [11:0] paddr, conv_data;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  conv_ch;
    logic [1:0]  ref_sel, res_sel, cmp_band;
    logic [3:0]  phase_sel;
    logic [4:0]  chs[$];
    logic [4:0]  bch[4] = '{5'h08, 5'h09, 5'h10, 5'h11};
    logic [1:0]  bexp[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    int          errors, comparisons, cycles, starts, dones, lat, dly, s;

    adcs_ctrl uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ext_trig(ext_trig),
        .conv_start(conv_start), .conv_ch(conv_ch), .conv_done(conv_done),
        .conv_data(conv_data), .ref_sel(ref_sel), .res_sel(res_sel),
        .phase_sel(phase_sel), .cmp_band(cmp_band), .irq(irq));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Converter answers after lat cycles; data is channel times 32, plus 2 on odd answers while jit is set
    always @(posedge clock) begin
        cycles++;
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start) begin
            starts++;
            chs.push_back(conv_ch);
            dly <= lat;
        end else if (dly > 0) begin
            dly <= dly - 1;
            if (dly == 1) begin
                conv_done <= 1'b1;
                conv_data <= {2'h0, conv_ch, 5'h0}
                             + ((jit && dones[0]) ? 12'h2 : 12'h0);
                dones++;
            end
        end
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the bench timeout ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic wait_done(input int n);
        int k;
        k = 0;
        while (dones < n && k < 2000) begin
            @(posedge clock);
            k++;
        end
        chk(32'(dones >= n), 32'h1);
        repeat (4) @(posedge clock);
    endtask : wait_done

    // Single step on the last sequencer, interrupt and end marked
    task automatic run3(input logic [4:0] ch, input int cnt);
        int n;
        n = dones;
        wr(`ADCS_OFF_EN, 32'h0);
        wr(`ADCS_OFF_STEP + 12'h040, {25'h0, 2'b11, ch});
        wr(`ADCS_OFF_EN, 32'h8);
        wr(`ADCS_OFF_PTRIG, 32'h8);
        wait_done(n + cnt);
    endtask : run3

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        ext_trig = 1'b0;
        conv_done = 1'b0;
        conv_data = 12'h0;
        jit = 1'b0;
        lat = 1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(`ADCS_OFF_PRIO, 32'he4);
        rd(`ADCS_OFF_EN, 32'h0);
        apb(1'b0, 12'h034, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(`ADCS_OFF_MISC, 32'ha7);
        rd(`ADCS_OFF_MISC, 32'ha7);
        chk({24'h0, phase_sel, res_sel, ref_sel}, 32'ha7);
        wr(`ADCS_OFF_TSRC, 32'h0);
        wr(`ADCS_OFF_IM, 32'h8);
        wr(`ADCS_OFF_CMP, 32'h0200_0100);
        run3(`ADCS_CH_TEMP, 1);
        chk({31'h0, irq}, 32'h1);
        rd(`ADCS_OFF_RIS, 32'h8);
        rd(`ADCS_OFF_ISC, 32'h8);
        chk({30'h0, cmp_band}, 32'h2);
        rd(`ADCS_OFF_FIFO + 12'h00c, 32'h300);
        rd(`ADCS_OFF_FIFO + 12'h00c, 32'h0);
        rd(`ADCS_OFF_UFL, 32'h8);
        rd(`ADCS_OFF_OVF, 32'h0);
        wr(`ADCS_OFF_UFL, 32'h8);
        wr(`ADCS_OFF_ISC, 32'h8);
        rd(`ADCS_OFF_UFL, 32'h0);
        rd(`ADCS_OFF_RIS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Band edges: equal to a reference stays in the lower band
        for (int i = 0; i < 4; i++) begin
            run3(bch[i], 1);
            chk({30'h0, cmp_band}, {30'h0, bexp[i]});
            rd(`ADCS_OFF_BAND, {30'h0, bexp[i]});
            rd(`ADCS_OFF_FIFO + 12'h00c, {22'h0, bch[i], 5'h0});
        end
        // First sequencer: full depth, repeated and mixed channels
        wr(`ADCS_OFF_EN, 32'h0);
        wr(`ADCS_OFF_ISC, 32'h8);
        for (int i = 0; i < 8; i++) begin
            wr(`ADCS_OFF_STEP + 12'(4 * i),
               {25'h0, 1'b0, i == 7, 5'((i / 2 * 3) % 5)});
        end
        chs.delete();
        s = dones;
        wr(`ADCS_OFF_EN, 32'h1);
        wr(`ADCS_OFF_PTRIG, 32'h1);
        wait_done(s + 8);
        chk(32'(chs.size()), 32'h8);
        for (int i = 0; i < 8; i++) begin
            chk({27'h0, chs[i]}, 32'((i / 2 * 3) % 5));
            rd(`ADCS_OFF_FIFO, 32'(((i / 2 * 3) % 5) * 32));
        end
        rd(`ADCS_OFF_RIS, 32'h1);
        rd(`ADCS_OFF_ISC, 32'h0);
        wr(`ADCS_OFF_RIS, 32'h1);
        // Simultaneous triggers, third sequencer ranked first
        wr(`ADCS_OFF_EN, 32'h0);
        wr(`ADCS_OFF_STEP + 12'h020, 32'h41);
        wr(`ADCS_OFF_STEP + 12'h030, 32'h42);
        wr(`ADCS_OFF_PRIO, 32'h4b);
        wr(`ADCS_OFF_OSMP, 32'h1);
        jit = 1'b1;
        lat = 6;
        chs.delete();
        s = dones;
        wr(`ADCS_OFF_EN, 32'h6);
        wr(`ADCS_OFF_PTRIG, 32'h6);
        wait_done(s + 4);
        chk({27'h0, chs[0]}, 32'h2);
        chk({27'h0, chs[3]}, 32'h1);
        rd(`ADCS_OFF_FIFO + 12'h008, 32'h41);
        rd(`ADCS_OFF_FIFO + 12'h004, 32'h21);
        for (int n = 1; n < 7; n++) begin
            wr(`ADCS_OFF_OSMP, 32'(n));
            s = starts;
            run3(5'd5, 1 << n);
            chk(32'(starts - s), 32'(1 << n));
            rd(`ADCS_OFF_FIFO + 12'h00c, 32'ha1);
        end
        wr(`ADCS_OFF_OSMP, 32'h7);
        rd(`ADCS_OFF_OSMP, 32'h6);
        wr(`ADCS_OFF_OSMP, 32'h0);
        jit = 1'b0;
        lat = 1;
        // External pin, then always trigger until disabled
        wr(`ADCS_OFF_EN, 32'h0);
        wr(`ADCS_OFF_TSRC, 32'h40);
        wr(`ADCS_OFF_EN, 32'h8);
        s = dones;
        ext_trig <= 1'b1;
        wait_done(s + 1);
        ext_trig <= 1'b0;
        rd(`ADCS_OFF_FIFO + 12'h00c, 32'ha0);
        wr(`ADCS_OFF_TSRC, 32'h80);
        repeat (100) @(posedge clock);
        wr(`ADCS_OFF_EN, 32'h0);
        repeat (20) @(posedge clock);
        s = starts;
        wr(`ADCS_OFF_PTRIG, 32'h8);
        repeat (20) @(posedge clock);
        chk(32'(starts - s), 32'h0);
        rd(`ADCS_OFF_OVF, 32'h8);
        rd(`ADCS_OFF_UFL, 32'h0);
        wr(`ADCS_OFF_OVF, 32'h8);
        rd(`ADCS_OFF_OVF, 32'h0);
        // Last sequencer still flags its step, so masking drops the line
        chk({31'h0, irq}, 32'h1);
        wr(`ADCS_OFF_IM, 32'h0);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        close_out();
    end
endmodule : adc_sample_sequencer_control_test
